// ===== verilog/bst_tap_top.sv
// Boundary-scan test port: controller, instruction decode, data registers, pad muxing
//
// Behaviour
// - Provides bypass, sample/preload and external-test instructions through a test port.
// - When enabled, three pins become test inputs and one becomes test output.
// - No test reset pin; controller resets by holding TMS high or while the port is off.
// - Sixteen-state controller, instruction register with decode, several data registers.
// - Each pad cell gives three boundary bits: input, output, output enable.
// - Program, config clock and config-complete pins have no boundary cells.
// - External-test capture loads every input, output and enable cell together.
// - Bits 0 and 1 capture internal signals; last bit is an update cell.
// - Shift order per pad is input, output, enable; all pads are full.
// - Bypass is one flip-flop between TDI and TDO.
// - Two user selects decode user instructions; their returns drive TDO.
// - A data-register shift clock is offered to user logic.
// - Idle output is NAND of TCK and run-test/idle.
// - Codes 000 external test, 001 sample, 110 reserved, 111 bypass.
// - 010/011 user scans, 100 readback, 101 configure with pads off.
// - Without the scan primitive the port works only during configuration.
// - TMS, TCK and TDI stay readable by user logic.
// - Global output disable floats pads unless external test is running.
`timescale 1ns/1ps
module bst_tap_top (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          tck_i,
    input  wire logic                          tms_i,
    input  wire logic                          tdi_i,
    output logic                               tdo_o,
    output logic                               tdo_oe_n_o,
    input  wire logic                          scan_primitive_present_i,
    input  wire logic                          config_done_i,
    input  wire logic                          user_tdo_i,
    input  wire logic                          user_tdo_oe_n_i,
    input  wire logic                          global_output_disable_i,
    input  wire bst_pkg::bst_drive_t           user_drive_i,
    input  wire logic [bst_pkg::NUM_PADS-1:0]  pad_in_i,
    output bst_pkg::bst_drive_t                pad_drive_o,
    output logic      [bst_pkg::NUM_PADS-1:0]  pad_in_o,
    output logic                               tck_user_o,
    output logic                               tms_user_o,
    output logic                               tdi_user_o,
    input  wire logic [1:0]                    internal_capture_i,
    output logic                               internal_update_cell_o,
    output logic                               user_scan_one_select_o,
    output logic                               user_scan_two_select_o,
    input  wire logic                          user_scan_one_return_i,
    input  wire logic                          user_scan_two_return_i,
    output logic                               user_shift_clock_o,
    output logic                               idle_nand_output_o,
    input  wire logic                          readback_data_i,
    input  wire logic                          config_dout_i,
    output logic                               readback_select_o,
    output logic                               config_select_o
);
    // =====================================================================
    // Declarations
    // =====================================================================
    localparam int NP   = bst_pkg::NUM_PADS;
    localparam int BLEN = bst_pkg::BSR_LEN;

    logic [bst_pkg::PIN_SYNC_W-1:0] pins_c;
    logic [bst_pkg::TO_TCK_W-1:0]   to_tck_t;
    logic [bst_pkg::TO_CLK_W-1:0]   to_clk_c;

    bst_pkg::bst_state_t   state;
    logic                  port_active_t;
    logic [1:0]            int_cap_t;
    logic [NP-1:0]         pad_in_t;
    bst_pkg::bst_drive_t   drive_t;

    logic [2:0]            ir = bst_pkg::IR_RESET;
    logic [2:0]            next_ir;
    logic [2:0]            ir_sr;
    logic [BLEN-1:0]       bsr_sr;
    logic [BLEN-1:0]       bsr_upd;
    wire logic [BLEN-1:0]  bsr_cap;
    wire bst_pkg::bst_drive_t upd_t;
    logic                  bypass_q;
    logic                  bsr_sel;
    logic                  dr_out;
    logic                  tdo_t = 1'b0;
    logic                  tdo_oe_n_t = 1'b1;
    logic                  drck_en = 1'b0;
    logic                  rti_q = 1'b0;
    logic                  extest_t = 1'b0;
    logic                  config_t = 1'b0;

    logic                  port_active_c;
    logic                  extest_c;
    logic                  config_c;
    bst_pkg::bst_drive_t   upd_c;
    logic                  user_tdo_q;
    logic                  user_tdo_oe_n_q;

    // =====================================================================
    // Pin synchronisers into the system clock
    // =====================================================================
    bst_sync #(.W(bst_pkg::PIN_SYNC_W)) u_pin_sync (
        .clk_i (clk_i),
        .d_i   ({tck_i, tms_i, tdi_i, pad_in_i}),
        .q_o   (pins_c)
    );

    // Test pins stay routable to user logic
    assign tck_user_o = pins_c[NP+2];
    assign tms_user_o = pins_c[NP+1];
    assign tdi_user_o = pins_c[NP];
    assign pad_in_o   = pins_c[NP-1:0];

    // =====================================================================
    // Crossings between the two domains (quasi-static levels)
    // =====================================================================
    // Pad drive is seen two TCK edges late; capture of quasi-static pads tolerates it
    bst_sync #(.W(bst_pkg::TO_TCK_W)) u_to_tck (
        .clk_i (tck_i),
        .d_i   ({port_active_c, 1'b0, internal_capture_i, pins_c[NP-1:0], pad_drive_o}),
        .q_o   (to_tck_t)
    );

    assign port_active_t = to_tck_t[bst_pkg::TO_TCK_W-1];
    assign int_cap_t     = to_tck_t[3*NP+1:3*NP];
    assign pad_in_t      = to_tck_t[3*NP-1:2*NP];
    assign drive_t       = to_tck_t[2*NP-1:0];

    // Decode and update image reach the pad logic as levels, two CLK flops late
    bst_sync #(.W(bst_pkg::TO_CLK_W)) u_to_clk (
        .clk_i (clk_i),
        .d_i   ({extest_t, config_t, upd_t}),
        .q_o   (to_clk_c)
    );

    assign extest_c = to_clk_c[2*NP+1];
    assign config_c = to_clk_c[2*NP];
    assign upd_c    = to_clk_c[2*NP-1:0];

    // =====================================================================
    // Controller
    // =====================================================================
    bst_tap_ctrl u_tap (
        .tck_i         (tck_i),
        .tms_i         (tms_i),
        .force_reset_i (!port_active_t),
        .state_o       (state)
    );

    // =====================================================================
    // Instruction register: shift on rising TCK, update on falling TCK
    // =====================================================================
    always_ff @(posedge tck_i) begin
        if (state == bst_pkg::ST_CIR) begin
            ir_sr <= bst_pkg::IR_CAPTURE;
        end else if (state == bst_pkg::ST_SHIR) begin
            ir_sr <= {tdi_i, ir_sr[2:1]};
        end
    end

    always_comb begin
        next_ir = ir;
        if (state == bst_pkg::ST_TLR) begin
            next_ir = bst_pkg::IR_RESET;
        end else if (state == bst_pkg::ST_UIR) begin
            next_ir = ir_sr;
        end
    end

    always_ff @(negedge tck_i) begin
        ir                     <= next_ir;
        user_scan_one_select_o <= (next_ir == bst_pkg::IR_USER1);
        user_scan_two_select_o <= (next_ir == bst_pkg::IR_USER2);
        readback_select_o      <= (next_ir == bst_pkg::IR_READBACK);
        config_select_o        <= (next_ir == bst_pkg::IR_CONFIG);
        extest_t               <= (next_ir == bst_pkg::IR_EXTEST);
        config_t               <= (next_ir == bst_pkg::IR_CONFIG);
    end

    // =====================================================================
    // Boundary register: capture image per cell
    // =====================================================================
    assign bsr_sel = (ir == bst_pkg::IR_EXTEST) || (ir == bst_pkg::IR_SAMPLE);

    assign bsr_cap[bst_pkg::IDX_TDO_T]    = int_cap_t[0];
    assign bsr_cap[bst_pkg::IDX_TDO_O]    = int_cap_t[1];
    assign bsr_cap[bst_pkg::IDX_UPD_CELL] = bsr_upd[bst_pkg::IDX_UPD_CELL];

    genvar k;
    generate
        for (k = 0; k < NP; k++) begin : g_pad
            localparam int BASE = bst_pkg::IDX_PAD_BASE + bst_pkg::CELLS_PER_PAD * k;
            assign bsr_cap[BASE + bst_pkg::CELL_IN]  = pad_in_t[k];
            assign bsr_cap[BASE + bst_pkg::CELL_OUT] = drive_t.out[k];
            assign bsr_cap[BASE + bst_pkg::CELL_OE]  = drive_t.oe_n[k];
            assign upd_t.out[k]  = bsr_upd[BASE + bst_pkg::CELL_OUT];
            assign upd_t.oe_n[k] = bsr_upd[BASE + bst_pkg::CELL_OE];
        end
    endgenerate

    // All cells load in one capture edge
    always_ff @(posedge tck_i) begin
        if (bsr_sel && state == bst_pkg::ST_CDR) begin
            bsr_sr <= bsr_cap;
        end else if (bsr_sel && state == bst_pkg::ST_SHDR) begin
            bsr_sr <= {tdi_i, bsr_sr[BLEN-1:1]};
        end
    end

    // Update stage changes only while TCK is low, so pads see a settled image
    always_ff @(negedge tck_i) begin
        if (bsr_sel && state == bst_pkg::ST_UDR) begin
            bsr_upd                <= bsr_sr;
            internal_update_cell_o <= bsr_sr[bst_pkg::IDX_UPD_CELL];
        end
    end

    // =====================================================================
    // Bypass register
    // =====================================================================
    always_ff @(posedge tck_i) begin
        if (state == bst_pkg::ST_CDR) begin
            bypass_q <= 1'b0;
        end else if (state == bst_pkg::ST_SHDR) begin
            bypass_q <= tdi_i;
        end
    end

    // =====================================================================
    // TDO source and falling-edge output stage
    // =====================================================================
    always_comb begin
        case (ir)
            bst_pkg::IR_EXTEST:   dr_out = bsr_sr[0];
            bst_pkg::IR_SAMPLE:   dr_out = bsr_sr[0];
            bst_pkg::IR_USER1:    dr_out = user_scan_one_return_i;
            bst_pkg::IR_USER2:    dr_out = user_scan_two_return_i;
            bst_pkg::IR_READBACK: dr_out = readback_data_i;
            bst_pkg::IR_CONFIG:   dr_out = config_dout_i;
            default:              dr_out = bypass_q;
        endcase
    end

    always_ff @(negedge tck_i) begin
        if (state == bst_pkg::ST_SHIR) begin
            tdo_t <= ir_sr[0];
        end else if (state == bst_pkg::ST_SHDR) begin
            tdo_t <= dr_out;
        end
        tdo_oe_n_t <= !(state == bst_pkg::ST_SHIR || state == bst_pkg::ST_SHDR);
    end

    // =====================================================================
    // User hooks: shift clock and idle indication
    // =====================================================================
    always_ff @(negedge tck_i) begin
        drck_en <= (user_scan_one_select_o || user_scan_two_select_o)
                   && (state == bst_pkg::ST_CDR || state == bst_pkg::ST_SHDR);
        rti_q   <= (state == bst_pkg::ST_RTI);
    end

    // Gate opened while TCK is low, so no runt pulse
    assign user_shift_clock_o = drck_en & tck_i;
    assign idle_nand_output_o = !(tck_i & rti_q);

    // =====================================================================
    // System clock side: port ownership and pad drive
    // =====================================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            port_active_c   <= 1'b1;
            user_tdo_q      <= 1'b0;
            user_tdo_oe_n_q <= 1'b1;
        end else begin
            port_active_c   <= scan_primitive_present_i || !config_done_i;
            user_tdo_q      <= user_tdo_i;
            user_tdo_oe_n_q <= user_tdo_oe_n_i;
        end
    end

    // Test output pin is dedicated while the port is live, user pin otherwise
    // Port off hands the pin back to user logic
    assign tdo_o      = port_active_c ? tdo_t : user_tdo_q;
    assign tdo_oe_n_o = port_active_c ? tdo_oe_n_t : user_tdo_oe_n_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pad_drive_o.out  <= bst_pkg::PADS_LOW;
            pad_drive_o.oe_n <= bst_pkg::PADS_OFF;
        end else if (extest_c && port_active_c) begin
            pad_drive_o <= upd_c;
        end else if (global_output_disable_i || config_c) begin
            pad_drive_o.out  <= user_drive_i.out;
            pad_drive_o.oe_n <= bst_pkg::PADS_OFF;
        end else begin
            pad_drive_o <= user_drive_i;
        end
    end

    // =====================================================================
    // Checks, test clock domain
    // =====================================================================
    a_ir_capture_val: assert property (@(posedge tck_i) disable iff (!port_active_t)
        (state == bst_pkg::ST_CIR) |=> (ir_sr == bst_pkg::IR_CAPTURE))
        else $error("instruction capture pattern wrong");

    a_bypass_one_bit: assert property (@(posedge tck_i) disable iff (!port_active_t)
        (ir == bst_pkg::IR_BYPASS && state == bst_pkg::ST_SHDR)
        |=> (bypass_q == $past(tdi_i)))
        else $error("bypass register is not a single stage");

    a_extest_capture: assert property (@(posedge tck_i) disable iff (!port_active_t)
        (ir == bst_pkg::IR_EXTEST && state == bst_pkg::ST_CDR)
        |=> (bsr_sr[bst_pkg::IDX_PAD_BASE] == $past(pad_in_t[0]))
            && (bsr_sr[bst_pkg::IDX_TDO_T] == $past(int_cap_t[0])))
        else $error("external-test capture missed a cell");

    a_user_one_ret: assert property (@(posedge tck_i) disable iff (!port_active_t)
        (ir == bst_pkg::IR_USER1 && state == bst_pkg::ST_SHDR && $stable(ir))
        |=> (tdo_t == $past(user_scan_one_return_i)))
        else $error("user scan one return not on TDO");

    // =====================================================================
    // Checks, system clock domain
    // =====================================================================
    a_gts_float_pads: assert property (@(posedge clk_i) disable iff (reset_i)
        (global_output_disable_i && !extest_c) |=> (pad_drive_o.oe_n == bst_pkg::PADS_OFF))
        else $error("pads driven under global output disable");

    a_extest_drives: assert property (@(posedge clk_i) disable iff (reset_i)
        (extest_c && port_active_c) |=> (pad_drive_o == $past(upd_c)))
        else $error("pads not taken from boundary update cells");

    a_config_off_pads: assert property (@(posedge clk_i) disable iff (reset_i)
        (config_c && !extest_c) |=> (pad_drive_o.oe_n == bst_pkg::PADS_OFF))
        else $error("pads driven during configure instruction");

    a_tms_user_path: assert property (@(posedge clk_i) disable iff (reset_i)
        ##2 (tms_user_o == $past(tms_i, 2)))
        else $error("TMS not routed to user logic after two stages");

endmodule

// ===== inc/bst_pkg.sv
// Constants, encodings and carrier types shared by the boundary-scan test port
package bst_pkg;

    // =====================================================================
    // Pad population
    // =====================================================================
    localparam int NUM_PADS      = 4;
    localparam int CELLS_PER_PAD = 3;
    localparam int IDX_TDO_T     = 0;
    localparam int IDX_TDO_O     = 1;
    localparam int IDX_PAD_BASE  = 2;
    localparam int CELL_IN       = 0;
    localparam int CELL_OUT      = 1;
    localparam int CELL_OE       = 2;
    // Program-request, config clock and config-complete pins carry no cells
    localparam int BSR_LEN       = IDX_PAD_BASE + CELLS_PER_PAD * NUM_PADS + 1;
    localparam int IDX_UPD_CELL  = BSR_LEN - 1;

    // =====================================================================
    // Instruction register
    // =====================================================================
    localparam int         IR_LEN      = 3;
    localparam logic [2:0] IR_EXTEST   = 3'h0;
    localparam logic [2:0] IR_SAMPLE   = 3'h1;
    localparam logic [2:0] IR_USER1    = 3'h2;
    localparam logic [2:0] IR_USER2    = 3'h3;
    localparam logic [2:0] IR_READBACK = 3'h4;
    localparam logic [2:0] IR_CONFIG   = 3'h5;
    localparam logic [2:0] IR_RESERVED = 3'h6;
    localparam logic [2:0] IR_BYPASS   = 3'h7;
    localparam logic [2:0] IR_CAPTURE  = 3'h1;
    localparam logic [2:0] IR_RESET    = IR_BYPASS;

    // =====================================================================
    // Crossing widths and reset values
    // =====================================================================
    localparam int          PIN_SYNC_W  = 3 + NUM_PADS;
    localparam int          TO_TCK_W    = 4 + 3 * NUM_PADS;
    localparam int          TO_CLK_W    = 2 + 2 * NUM_PADS;
    localparam logic [3:0]  PADS_OFF    = 4'hF;
    localparam logic [3:0]  PADS_LOW    = 4'h0;

    // =====================================================================
    // Controller states, Gray steps along the data-register path
    // =====================================================================
    typedef enum logic [3:0] {
        ST_TLR  = 4'h0,
        ST_RTI  = 4'h1,
        ST_SDR  = 4'h3,
        ST_CDR  = 4'h2,
        ST_SHDR = 4'h6,
        ST_E1DR = 4'h7,
        ST_PDR  = 4'h5,
        ST_E2DR = 4'h4,
        ST_UDR  = 4'hC,
        ST_SIR  = 4'hD,
        ST_CIR  = 4'hF,
        ST_SHIR = 4'hE,
        ST_E1IR = 4'hA,
        ST_PIR  = 4'hB,
        ST_E2IR = 4'h9,
        ST_UIR  = 4'h8
    } bst_state_t;

    typedef struct packed {
        logic [NUM_PADS-1:0] out;
        logic [NUM_PADS-1:0] oe_n;
    } bst_drive_t;

endpackage

// ===== verilog/bst_sync.sv
// Two-flop level synchroniser for a bundle of quasi-static bits
`timescale 1ns/1ps
module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // =====================================================================
    // Synchroniser chain
    // =====================================================================
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        meta <= d_i;
        q_o  <= meta;
    end

endmodule

// ===== verilog/bst_tap_ctrl.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
module bst_tap_ctrl (
    input  wire logic              tck_i,
    input  wire logic              tms_i,
    input  wire logic              force_reset_i,
    output bst_pkg::bst_state_t    state_o
);
    // =====================================================================
    // State register, no reset pin: only TMS or the port-off force
    // =====================================================================
    bst_pkg::bst_state_t next_state;
    bst_pkg::bst_state_t state = bst_pkg::ST_TLR;

    assign state_o = state;

    always_comb begin
        case (state)
            bst_pkg::ST_TLR:  next_state = tms_i ? bst_pkg::ST_TLR  : bst_pkg::ST_RTI;
            bst_pkg::ST_RTI:  next_state = tms_i ? bst_pkg::ST_SDR  : bst_pkg::ST_RTI;
            bst_pkg::ST_SDR:  next_state = tms_i ? bst_pkg::ST_SIR  : bst_pkg::ST_CDR;
            bst_pkg::ST_CDR:  next_state = tms_i ? bst_pkg::ST_E1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_SHDR: next_state = tms_i ? bst_pkg::ST_E1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_E1DR: next_state = tms_i ? bst_pkg::ST_UDR  : bst_pkg::ST_PDR;
            bst_pkg::ST_PDR:  next_state = tms_i ? bst_pkg::ST_E2DR : bst_pkg::ST_PDR;
            bst_pkg::ST_E2DR: next_state = tms_i ? bst_pkg::ST_UDR  : bst_pkg::ST_SHDR;
            bst_pkg::ST_UDR:  next_state = tms_i ? bst_pkg::ST_SDR  : bst_pkg::ST_RTI;
            bst_pkg::ST_SIR:  next_state = tms_i ? bst_pkg::ST_TLR  : bst_pkg::ST_CIR;
            bst_pkg::ST_CIR:  next_state = tms_i ? bst_pkg::ST_E1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_SHIR: next_state = tms_i ? bst_pkg::ST_E1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_E1IR: next_state = tms_i ? bst_pkg::ST_UIR  : bst_pkg::ST_PIR;
            bst_pkg::ST_PIR:  next_state = tms_i ? bst_pkg::ST_E2IR : bst_pkg::ST_PIR;
            bst_pkg::ST_E2IR: next_state = tms_i ? bst_pkg::ST_UIR  : bst_pkg::ST_SHIR;
            bst_pkg::ST_UIR:  next_state = tms_i ? bst_pkg::ST_SDR  : bst_pkg::ST_RTI;
            default:          next_state = bst_pkg::ST_TLR;
        endcase
    end

    // Rising-edge sampling of TMS
    always_ff @(posedge tck_i) begin
        if (force_reset_i) begin
            state <= bst_pkg::ST_TLR;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    sequence s_five_high;
        tms_i [*5];
    endsequence

    a_tms_reset_walk: assert property (@(posedge tck_i) disable iff (force_reset_i)
        s_five_high |=> (state_o == bst_pkg::ST_TLR))
        else $error("five TMS highs did not reach test-logic reset");

    a_shift_dr_entry: assert property (@(posedge tck_i) disable iff (force_reset_i)
        (state_o == bst_pkg::ST_RTI && tms_i) ##1 !tms_i ##1 !tms_i
        |=> (state_o == bst_pkg::ST_SHDR))
        else $error("path idle to shift-DR broken");

endmodule

// ===== dv/bst_host.sv
// Test controller model that drives the four-pin test port
`timescale 1ns/1ps
module bst_host (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // ====
    // One 64 ns test clock; TDO is taken just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #32;
        q = tdo_i;
        tck_o = 1'b1;
        #32;
        tck_o = 1'b0;
    endtask
    task automatic reset_port();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    // From idle, shift n bits through IR or DR, then back to idle
    task automatic scan(input logic ir, input logic [15:0] d, input int n,
                        output logic [15:0] q);
        logic b;
        q = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

// ===== dv/boundary_scan_tap_test.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_tap_test;
    logic                clk_i = 1'b0, reset_i = 1'b1, global_output_disable = 1'b0, ret = 1'b1, prs = 1'b1;
    logic                tck, tms, tdi, tdo, upd, s1, s2, rb, cf, idl, toe, tcu, tmu, tdu;
    logic [3:0]          pin;
    bst_pkg::bst_drive_t drv = 8'h50, pad;
    logic [15:0]         q;
    int                  errors = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    bst_host u_bst_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    bst_tap_top u_bst_tap_top (.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(toe), .scan_primitive_present_i(prs),
        .config_done_i(1'b1), .user_tdo_i(1'b1), .user_tdo_oe_n_i(1'b1),
        .global_output_disable_i(global_output_disable), .user_drive_i(drv), .pad_in_i(4'hA),
        .pad_drive_o(pad), .pad_in_o(pin), .tck_user_o(tcu), .tms_user_o(tmu), .tdi_user_o(tdu),
        .internal_capture_i(2'h2), .internal_update_cell_o(upd),
        .user_scan_one_select_o(s1), .user_scan_two_select_o(s2),
        .user_scan_one_return_i(ret), .user_scan_two_return_i(~ret),
        .user_shift_clock_o(), .idle_nand_output_o(idl), .readback_data_i(ret),
        .config_dout_i(~ret), .readback_select_o(rb), .config_select_o(cf));
    // ====
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_bypass();
        logic b;
        for (int c = 7; c > 5; c--) begin
            u_bst_host.scan(1'b1, 16'(c), 3, q);
            check(q, 16'h0001);
            u_bst_host.scan(1'b0, 16'h000D, 5, q);
            check(q, 16'h001A);
        end
        check({15'h0, idl}, 16'h0001);
        fork
            u_bst_host.step(1'b0, 1'b1, b);
            begin
                #48;
                check({15'h0, idl}, 16'h0000);
            end
        join
        repeat (3) @(negedge clk_i);
        check({9'h0, pin, tcu, tmu, tdu}, 16'h0051);
        $display("bypass test done");
    endtask
    task automatic t_user();
        for (int c = 2; c < 6; c++) begin
            u_bst_host.scan(1'b1, 16'(c), 3, q);
            repeat (4) @(negedge clk_i);
            check({12'h0, cf, rb, s2, s1}, 16'h1 << (c - 2));
            check({12'h0, pad.oe_n}, (c == 5) ? 16'h000F : 16'h0000);
            u_bst_host.scan(1'b0, 16'h0000, 4, q);
            check(q, c[0] ? 16'h0000 : 16'h000F);
        end
        $display("user test done");
    endtask
    task automatic t_extest();
        @(negedge clk_i);
        global_output_disable = 1'b1;
        u_bst_host.scan(1'b1, 16'h0001, 3, q);
        u_bst_host.scan(1'b0, 16'h0000, 15, q);
        check(q & 16'h3FFF, 16'h2EBA);
        repeat (6) @(negedge clk_i);
        check({8'h0, pad}, 16'h005F);
        u_bst_host.scan(1'b1, 16'h0000, 3, q);
        repeat (6) @(negedge clk_i);
        check({8'h0, pad}, 16'h0000);
        u_bst_host.scan(1'b0, 16'h5248, 15, q);
        check(q & 16'h0927, 16'h0822);
        check(q & 16'h76D8, 16'h0000);
        repeat (6) @(negedge clk_i);
        check({8'h0, pad}, 16'h00F0);
        check({15'h0, upd}, 16'h0001);
        u_bst_host.scan(1'b1, 16'h0007, 3, q);
        repeat (6) @(negedge clk_i);
        check({12'h0, pad.oe_n}, 16'h000F);
        $display("extest test done");
    endtask
    task automatic t_port_off();
        prs = 1'b0;
        repeat (3) @(negedge clk_i);
        u_bst_host.scan(1'b1, 16'h0002, 3, q);
        check(q, 16'h0007);
        repeat (4) @(negedge clk_i);
        check({11'h0, toe, cf, rb, s2, s1}, 16'h0010);
        prs = 1'b1;
        repeat (3) @(negedge clk_i);
        u_bst_host.reset_port();
        $display("port off test done");
    endtask
    initial begin
        #300000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        u_bst_host.reset_port();
        t_bypass();
        t_user();
        t_extest();
        t_port_off();
        finish_test();
    end
endmodule
